//--- ir_carrier_gen_model.sv
// Behavioural carrier generator that feeds the modulator under test.
`timescale 1ns/1ps
`default_nettype none

module ir_carrier_gen_model #(
  parameter int HIGH_A = 2,
  parameter int LOW_A  = 2,
  parameter int HIGH_B = 3,
  parameter int LOW_B  = 3
) (
  // Clock and reset
  input  wire logic core_clk,
  input  wire logic rst_n,
  // Modulator requests
  input  wire logic carrier_stop,
  input  wire logic carrier_swap,
  // Carrier towards the modulator
  output logic      carrier_in,
  output logic      carrier_period_tick
);
  logic sel_ff;
  int   cnt_ff;
  int   hi_len;
  int   lo_len;

  assign hi_len = sel_ff ? HIGH_B : HIGH_A;
  assign lo_len = sel_ff ? LOW_B : LOW_A;

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) sel_ff <= 1'b0;
    else if (carrier_swap) sel_ff <= ~sel_ff;
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_ff <= 0;
      carrier_in <= 1'b0;
      carrier_period_tick <= 1'b0;
    end else if (carrier_stop) begin
      cnt_ff <= 0;
      carrier_in <= 1'b1;
      carrier_period_tick <= 1'b0;
    end else begin
      carrier_period_tick <= 1'b0;
      if (cnt_ff >= (carrier_in ? hi_len : lo_len) - 1) begin
        cnt_ff <= 0;
        carrier_in <= ~carrier_in;
        carrier_period_tick <= ~carrier_in;
      end else cnt_ff <= cnt_ff + 1;
    end
  end
endmodule // ir_carrier_gen_model

`default_nettype wire

//--- ir_carrier_modulator.sv
// Mark/space modulator of the infrared transmitter with its APB register file.
// How it works
// R01: Time mode or FSK mode, chosen by mode bit.
// R02: Enable loads compare, counter and opens gate.
// R03: Counter underflow closes gate, output low.
// R04: Complement match reopens gate and reloads both.
// R05: Disable finishes current cycle, then output low.
// R06: Zero space compare gives no space.
// R07: Buffers written through three byte registers.
// R08: Counter readable as low byte and high nibble.
// R09: Time mode ticks every eight oscillator clocks.
// R10: Mark is buffer plus one, space buffer ticks.
// R11: Half rate doubles every mark and space.
// R12: Gate changes only while carrier is low; in unmodulated mode the code moves it while carrier is high.
// R13: Mark passes carrier, space forces low.
// R14: Unmodulated mode: mark high, space low.
// R15: FSK counts carrier periods for mark and space.
// R16: FSK mark expiry swaps carrier register sets.
// R17: FSK zero space switches sets back to back.
// R18: Extended space turns whole periods into space.
// R19: Software never starts with extended space set.
// R20: Match sets cycle end flag, raises enabled interrupt.
// R21: Status read then data byte access clears flag.
// R22: Service routine reloads buffers and clears flag.
// R23: Mode bit zero is time, reset clears it.
// R24: Unmodulated stops carrier, holds it high.
// R25: Pin follows modulator when running, else latch.
// R26: Reset leaves modulator idle, gate closed, low.
//
// Our own choice: the APB register port.
`timescale 1ns/1ps
`default_nettype none

module ir_carrier_modulator (
  // Clock and reset
  input  wire logic        core_clk,
  input  wire logic        rst_n,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [15:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // Carrier generator
  input  wire logic        carrier_in,
  input  wire logic        carrier_period_tick,
  output logic             carrier_swap,
  output logic             carrier_stop,
  // Transmitter and CPU
  output logic             infrared_out_pin,
  output logic             cycle_end_irq
);

  // ****************************************************************
  // Registers
  // ****************************************************************
  ir_mod_pkg::control_t   ctrl_ff;
  logic                   half_rate_ff;
  logic                   latch_ff;
  logic [11:0]            mark_buffer_ff;
  logic [11:0]            space_buffer_ff;
  logic [11:0]            space_compare_ff;
  logic [11:0]            cnt_ff;
  ir_mod_pkg::mod_state_t state_ff;
  logic                   ext_ff;
  logic                   flag_ff;
  logic                   armed_ff;
  logic [3:0]             pre_ff;
  logic                   half_tgl_ff;
  logic                   gate_sync_ff;
  logic                   ir_ff;
  logic                   swap_ff;
  logic [31:0]            rdata_ff;

  // ****************************************************************
  // Register decode
  // ****************************************************************
  logic        acc;
  logic        wr;
  logic        hit;
  logic [31:0] rd_val;
  logic        sel_ctrl;
  logic        sel_data_low;

  function automatic logic is_at(input logic [15:0] a, input logic [15:0] idx);
    return a == ir_mod_pkg::addr_of(idx);
  endfunction

  assign acc          = psel && penable;
  assign wr           = acc && pwrite && hit;
  assign sel_ctrl     = is_at(paddr, ir_mod_pkg::IDX_CONTROL_STATUS);
  assign sel_data_low = is_at(paddr, ir_mod_pkg::IDX_MARK_LOW) ||
                        is_at(paddr, ir_mod_pkg::IDX_SPACE_LOW);

  always_comb begin
    hit    = 1'b1;
    rd_val = 32'h0000_0000;
    if (sel_ctrl) begin
      rd_val[ir_mod_pkg::BIT_CYCLE_END] = flag_ff;
      rd_val[4:0] = ctrl_ff;
    end else if (is_at(paddr, ir_mod_pkg::IDX_UPPER_NIBBLES)) begin
      rd_val[7:0] = {mark_buffer_ff[11:8], space_buffer_ff[11:8]};
    end else if (is_at(paddr, ir_mod_pkg::IDX_MARK_LOW)) begin
      rd_val[7:0] = mark_buffer_ff[7:0];
    end else if (is_at(paddr, ir_mod_pkg::IDX_SPACE_LOW)) begin
      rd_val[7:0] = space_buffer_ff[7:0];
    end else if (is_at(paddr, ir_mod_pkg::IDX_ALT_CONTROL)) begin
      rd_val[ir_mod_pkg::BIT_HALF_RATE] = half_rate_ff;
    end else if (is_at(paddr, ir_mod_pkg::IDX_OUT_LATCH)) begin
      rd_val[ir_mod_pkg::BIT_LATCH] = latch_ff;
    end else if (is_at(paddr, ir_mod_pkg::IDX_COUNT_LOW)) begin
      rd_val[7:0] = cnt_ff[7:0]; // R08
    end else if (is_at(paddr, ir_mod_pkg::IDX_COUNT_HIGH)) begin
      rd_val[3:0] = cnt_ff[11:8]; // R08
    end else begin
      hit = 1'b0;
    end
  end

  // Read data is captured in the setup cycle and answered with no wait state.
  assign pready  = 1'b1;
  assign pslverr = acc && !hit;
  assign prdata  = rdata_ff;

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata_ff <= 32'h0000_0000;
    end else if (psel && !penable) begin
      rdata_ff <= rd_val;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_ff      <= ir_mod_pkg::CONTROL_RESET; // R23
      half_rate_ff <= 1'b0;
      latch_ff     <= 1'b0;
    end else if (wr && sel_ctrl) begin
      ctrl_ff <= pwdata[4:0];
    end else if (wr && is_at(paddr, ir_mod_pkg::IDX_ALT_CONTROL)) begin
      half_rate_ff <= pwdata[ir_mod_pkg::BIT_HALF_RATE];
    end else if (wr && is_at(paddr, ir_mod_pkg::IDX_OUT_LATCH)) begin
      latch_ff <= pwdata[ir_mod_pkg::BIT_LATCH];
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      mark_buffer_ff  <= ir_mod_pkg::BUFFER_RESET;
      space_buffer_ff <= ir_mod_pkg::BUFFER_RESET;
    end else if (wr) begin
      if (is_at(paddr, ir_mod_pkg::IDX_UPPER_NIBBLES)) begin
        mark_buffer_ff[11:8]  <= pwdata[7:4]; // R07
        space_buffer_ff[11:8] <= pwdata[3:0]; // R07
      end
      if (is_at(paddr, ir_mod_pkg::IDX_MARK_LOW)) begin
        mark_buffer_ff[7:0] <= pwdata[7:0]; // R07
      end
      if (is_at(paddr, ir_mod_pkg::IDX_SPACE_LOW)) begin
        space_buffer_ff[7:0] <= pwdata[7:0]; // R07
      end
    end
  end

  // ****************************************************************
  // Count rate
  // ****************************************************************
  logic tick;
  logic tick_time;
  logic tick_fsk;
  logic start;

  assign start     = (state_ff == ir_mod_pkg::MOD_IDLE) && ctrl_ff.enable;
  assign tick_time = pre_ff == (half_rate_ff ? ir_mod_pkg::PRE_LAST_X2 : ir_mod_pkg::PRE_LAST);
  assign tick_fsk  = carrier_period_tick && (!half_rate_ff || half_tgl_ff); // R11 R15
  assign tick      = ctrl_ff.mode_fsk ? tick_fsk : tick_time; // R01

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      pre_ff <= 4'h0;
    end else if (start || tick_time) begin
      pre_ff <= 4'h0; // R09 R11
    end else begin
      pre_ff <= pre_ff + 4'h1;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      half_tgl_ff <= 1'b0;
    end else if (start) begin
      half_tgl_ff <= 1'b0;
    end else if (carrier_period_tick) begin
      half_tgl_ff <= !half_tgl_ff; // R11
    end
  end

  // ****************************************************************
  // Mark and space sequencer
  // ****************************************************************
  logic [11:0] nxt_cnt;
  logic        underflow;
  logic        match;
  logic        cycle_end;

  assign nxt_cnt   = cnt_ff - 12'h001;
  assign underflow = (state_ff == ir_mod_pkg::MOD_MARK) && (cnt_ff == 12'h000); // R03 R10 R15
  assign match     = ((state_ff == ir_mod_pkg::MOD_SPACE) || underflow) &&
                     (~nxt_cnt == space_compare_ff); // R04 R06 R10 R15
  assign cycle_end = tick && match;

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_ff         <= ir_mod_pkg::MOD_IDLE; // R26
      cnt_ff           <= ir_mod_pkg::BUFFER_RESET;
      space_compare_ff <= ir_mod_pkg::BUFFER_RESET;
      ext_ff           <= 1'b0;
    end else if (start) begin
      state_ff         <= ir_mod_pkg::MOD_MARK; // R02
      cnt_ff           <= mark_buffer_ff; // R02
      space_compare_ff <= space_buffer_ff; // R02
      ext_ff           <= 1'b0; // R19
    end else if (tick && state_ff != ir_mod_pkg::MOD_IDLE) begin
      if (match && ctrl_ff.enable) begin
        state_ff         <= ir_mod_pkg::MOD_MARK; // R04
        cnt_ff           <= mark_buffer_ff; // R04 R20
        space_compare_ff <= space_buffer_ff; // R04
        ext_ff           <= ctrl_ff.ext_space; // R18
      end else if (match) begin
        state_ff <= ir_mod_pkg::MOD_IDLE; // R05
        ext_ff   <= 1'b0;
      end else begin
        cnt_ff <= nxt_cnt; // R04
        if (underflow) begin
          state_ff <= ir_mod_pkg::MOD_SPACE; // R03
        end
      end
    end
  end

  // A mark expiry in FSK mode tells the carrier generator to change sets.
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      swap_ff <= 1'b0;
    end else begin
      swap_ff <= tick && underflow && ctrl_ff.mode_fsk; // R16 R17
    end
  end

  // ****************************************************************
  // Gate, output and cycle end flag
  // ****************************************************************
  logic gate_want;
  logic carrier_eff;
  logic mod_out;

  assign gate_want   = (state_ff == ir_mod_pkg::MOD_MARK) && !ext_ff; // R13 R18
  assign carrier_eff = ctrl_ff.base || carrier_in; // R14 R24
  assign mod_out     = gate_sync_ff && carrier_eff; // R13 R14

  // Outside unmodulated mode the gate only moves while the carrier is low, so no pulse is cut short.
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      gate_sync_ff <= 1'b0; // R26
    end else if (ctrl_ff.base || !carrier_in) begin
      gate_sync_ff <= gate_want; // R12
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      ir_ff <= 1'b0;
    end else if (state_ff != ir_mod_pkg::MOD_IDLE) begin
      ir_ff <= mod_out; // R25
    end else begin
      ir_ff <= latch_ff; // R25
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      armed_ff <= 1'b0;
    end else if (acc && sel_ctrl && !pwrite) begin
      armed_ff <= 1'b1; // R21
    end else if (acc && sel_data_low) begin
      armed_ff <= 1'b0;
    end
  end

  // A new cycle end wins over a clear in the same cycle.
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      flag_ff <= 1'b0; // R26
    end else if (cycle_end) begin
      flag_ff <= 1'b1; // R20
    end else if (acc && sel_data_low && armed_ff) begin
      flag_ff <= 1'b0; // R21
    end
  end

  assign cycle_end_irq    = flag_ff && ctrl_ff.irq_en; // R20
  assign carrier_stop     = ctrl_ff.base; // R24
  assign carrier_swap     = swap_ff;
  assign infrared_out_pin = ir_ff;

  // ****************************************************************
  // Assertions
  // ****************************************************************
  a_idle_gate_closed: assert property (@(posedge core_clk) disable iff (!rst_n) // R26
    (state_ff == ir_mod_pkg::MOD_IDLE) && (ctrl_ff.base || !carrier_in) |=> !gate_sync_ff)
    else $error("Gate open while modulator idle.");

  a_space_output_low: assert property (@(posedge core_clk) disable iff (!rst_n) // R03
    (state_ff == ir_mod_pkg::MOD_SPACE) && !gate_sync_ff |=> !ir_ff)
    else $error("Output high during space.");

  a_reload_mark: assert property (@(posedge core_clk) disable iff (!rst_n) // R04
    cycle_end && ctrl_ff.enable |=> cnt_ff == $past(mark_buffer_ff) &&
                                    state_ff == ir_mod_pkg::MOD_MARK)
    else $error("Counter not reloaded at cycle end.");

  a_disable_stops: assert property (@(posedge core_clk) disable iff (!rst_n) // R05
    cycle_end && !ctrl_ff.enable |=> state_ff == ir_mod_pkg::MOD_IDLE)
    else $error("Modulator kept running after disable.");

  a_time_tick_rate: assert property (@(posedge core_clk) disable iff (!rst_n) // R09
    tick_time && !half_rate_ff && !start |=> (!tick_time && !start)[*7] ##0 !half_rate_ff
      |=> tick_time)
    else $error("Time tick spacing is not eight clocks.");

  a_tick_not_early: assert property (@(posedge core_clk) disable iff (!rst_n) // R09
    tick_time |=> (!tick_time)[*7])
    else $error("Time tick came early.");

  a_zero_space: assert property (@(posedge core_clk) disable iff (!rst_n) // R06
    tick && underflow && space_compare_ff == 12'h000 |-> cycle_end)
    else $error("Zero space did not end the cycle at once.");

  a_gate_sync: assert property (@(posedge core_clk) disable iff (!rst_n) // R12
    $changed(gate_sync_ff) && !$past(ctrl_ff.base) |-> !$past(carrier_in))
    else $error("Gate moved while carrier high.");

  a_fsk_swap: assert property (@(posedge core_clk) disable iff (!rst_n) // R16
    carrier_swap |-> $past(ctrl_ff.mode_fsk) && $past(state_ff) == ir_mod_pkg::MOD_MARK &&
                     $past(cnt_ff) == 12'h000)
    else $error("Swap outside FSK mark expiry.");

  a_flag_irq: assert property (@(posedge core_clk) disable iff (!rst_n) // R20
    cycle_end && ctrl_ff.irq_en && !(wr && sel_ctrl) |=> flag_ff && cycle_end_irq)
    else $error("Cycle end did not raise flag and interrupt.");

  a_flag_clear: assert property (@(posedge core_clk) disable iff (!rst_n) // R21
    flag_ff && !armed_ff && !cycle_end |=> flag_ff)
    else $error("Flag cleared without status read.");

  a_pin_latch: assert property (@(posedge core_clk) disable iff (!rst_n) // R25
    state_ff == ir_mod_pkg::MOD_IDLE |=> ir_ff == $past(latch_ff))
    else $error("Idle pin does not follow latch.");

endmodule // ir_carrier_modulator

`default_nettype wire

//--- ir_carrier_modulator_bench.sv
// Self-checking bench for the infrared mark/space modulator.
`timescale 1ns/1ps
`default_nettype none

module ir_carrier_modulator_bench;
  logic        core_clk, rst_n, psel, penable, pwrite, pready, pslverr;
  logic [15:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic        carrier_in, carrier_period_tick, carrier_swap, carrier_stop;
  logic        infrared_out_pin, cycle_end_irq, e;
  int          num_errors, n_checks, cycles, swaps, hi, lo, s0;

  ir_carrier_modulator i_ir_carrier_modulator (.core_clk(core_clk), .rst_n(rst_n),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .carrier_in(carrier_in),
    .carrier_period_tick(carrier_period_tick), .carrier_swap(carrier_swap),
    .carrier_stop(carrier_stop), .infrared_out_pin(infrared_out_pin),
    .cycle_end_irq(cycle_end_irq));

  ir_carrier_gen_model i_ir_carrier_gen_model (.core_clk(core_clk), .rst_n(rst_n),
    .carrier_stop(carrier_stop), .carrier_swap(carrier_swap), .carrier_in(carrier_in),
    .carrier_period_tick(carrier_period_tick));

  initial begin
    core_clk = 1'b0;
    forever #20 core_clk = ~core_clk;
  end

  always @(posedge core_clk) begin
    cycles <= cycles + 1;
    if (carrier_swap === 1'b1) swaps <= swaps + 1;
    if (cycles == 20000) begin
      num_errors = num_errors + 1;
      print_verdict();
    end
  end

  task automatic print_verdict();
    $display("checks %0d errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp) begin
      $display("BAD %s expected %h seen %h", nm, exp, got);
      num_errors++;
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask

  // APB transfer: setup, access held until pready is sampled high.
  task automatic xfer(input logic w, input logic [15:0] idx, input logic [7:0] d);
    int k;
    @(posedge core_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= {idx[13:0], 2'b00};
    pwdata <= {24'h000000, d};
    @(posedge core_clk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge core_clk);
      k++;
    end while (pready !== 1'b1 && k < 50);
    if (pready !== 1'b1) begin
      $display("BAD pready expected 1 seen %b", pready);
      num_errors++;
    end
    rd = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [15:0] idx, input logic [7:0] d);
    xfer(1'b1, idx, d);
  endtask

  task automatic start(input logic [7:0] ctl, input logic [7:0] alt,
                       input logic [11:0] m, input logic [11:0] s);
    wr(ir_mod_pkg::IDX_CONTROL_STATUS, 8'h00);
    tick(200);
    wr(ir_mod_pkg::IDX_UPPER_NIBBLES, {m[11:8], s[11:8]});
    wr(ir_mod_pkg::IDX_MARK_LOW, m[7:0]);
    wr(ir_mod_pkg::IDX_SPACE_LOW, s[7:0]);
    wr(ir_mod_pkg::IDX_ALT_CONTROL, alt);
    wr(ir_mod_pkg::IDX_CONTROL_STATUS, ctl);
  endtask

  task automatic count_high(input int n, output int c);
    c = 0;
    repeat (n) begin
      tick(1);
      if (infrared_out_pin === 1'b1) c++;
    end
  endtask

  // Times one high and one low stretch, starting at a rising edge of the pin.
  task automatic measure();
    int k;
    k = 0;
    while (infrared_out_pin !== 1'b0 && k < 500) begin
      tick(1);
      k++;
    end
    while (infrared_out_pin !== 1'b1 && k < 1000) begin
      tick(1);
      k++;
    end
    hi = 0;
    lo = 0;
    while (infrared_out_pin === 1'b1 && hi < 500) begin
      tick(1);
      hi++;
    end
    while (infrared_out_pin === 1'b0 && lo < 500) begin
      tick(1);
      lo++;
    end
  endtask

  task automatic t_reset();
    xfer(1'b0, ir_mod_pkg::IDX_CONTROL_STATUS, 8'h00);
    chk("control after reset", 32'h00000000, rd);
    chk("pin after reset", 32'h00000000, {31'h0, infrared_out_pin});
    xfer(1'b0, 16'h0030, 8'h5A);
    chk("unmapped error", 32'h00000001, {31'h0, e});
    chk("unmapped data", 32'h00000000, rd);
    wr(ir_mod_pkg::IDX_UPPER_NIBBLES, 8'hA5);
    xfer(1'b0, ir_mod_pkg::IDX_UPPER_NIBBLES, 8'h00);
    chk("upper nibbles", 32'h000000A5, rd);
  endtask

  task automatic t_baseband();
    swaps = 0;
    start(8'h09, 8'h00, 12'h003, 12'h002);
    measure();
    chk("base mark", 32'd32, hi);
    chk("base space", 32'd16, lo);
    chk("carrier stop", 32'h00000001, {31'h0, carrier_stop});
    chk("time swaps", 32'd0, swaps);
    xfer(1'b0, ir_mod_pkg::IDX_COUNT_HIGH, 8'h00);
    chk("count high nibble", 32'h00000000, rd);
  endtask

  task automatic t_flag();
    int k;
    xfer(1'b0, ir_mod_pkg::IDX_CONTROL_STATUS, 8'h00);
    start(8'h0B, 8'h00, 12'h003, 12'h002);
    tick(2);
    chk("irq before cycle end", 32'h00000000, {31'h0, cycle_end_irq});
    k = 0;
    while (cycle_end_irq !== 1'b1 && k < 200) begin
      tick(1);
      k++;
    end
    xfer(1'b0, ir_mod_pkg::IDX_CONTROL_STATUS, 8'h00);
    chk("flag set", 32'h00000001, {31'h0, rd[7]});
    wr(ir_mod_pkg::IDX_MARK_LOW, 8'h03);
    tick(1);
    chk("irq cleared", 32'h00000000, {31'h0, cycle_end_irq});
    xfer(1'b0, ir_mod_pkg::IDX_CONTROL_STATUS, 8'h00);
    chk("flag cleared", 32'h00000000, {31'h0, rd[7]});
  endtask

  task automatic t_disable();
    wr(ir_mod_pkg::IDX_CONTROL_STATUS, 8'h08);
    tick(200);
    count_high(60, hi);
    chk("idle pin low", 32'd0, hi);
    wr(ir_mod_pkg::IDX_OUT_LATCH, 8'h01);
    tick(3);
    chk("latch to pin", 32'h00000001, {31'h0, infrared_out_pin});
    wr(ir_mod_pkg::IDX_OUT_LATCH, 8'h00);
  endtask

  task automatic t_half();
    start(8'h09, 8'h01, 12'h003, 12'h002);
    measure();
    chk("half mark", 32'd64, hi);
    chk("half space", 32'd32, lo);
  endtask

  task automatic t_zero_ext();
    start(8'h09, 8'h00, 12'h003, 12'h000);
    tick(20);
    xfer(1'b0, ir_mod_pkg::IDX_COUNT_LOW, 8'h00);
    chk("count low", 32'h00000001, rd);
    count_high(120, hi);
    chk("no space", 32'd120, hi);
    start(8'h09, 8'h00, 12'h003, 12'h002);
    tick(60);
    wr(ir_mod_pkg::IDX_CONTROL_STATUS, 8'h19);
    tick(60);
    count_high(96, hi);
    chk("extended space", 32'd0, hi);
    wr(ir_mod_pkg::IDX_CONTROL_STATUS, 8'h09);
    count_high(120, hi);
    chk("mark resumes", 32'h00000001, {31'h0, hi > 0});
  endtask

  task automatic t_fsk();
    start(8'h05, 8'h00, 12'h001, 12'h000);
    s0 = swaps;
    tick(300);
    chk("fsk swaps", 32'h00000001, {31'h0, (swaps - s0) >= 20});
    count_high(100, hi);
    chk("carrier passes", 32'h00000001, {31'h0, hi > 10 && hi < 90});
  endtask

  initial begin
    rst_n = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 16'h0000;
    pwdata = 32'h00000000;
    num_errors = 0;
    n_checks = 0;
    cycles = 0;
    swaps = 0;
    repeat (16) @(posedge core_clk);
    rst_n <= 1'b1;
    t_reset();
    t_baseband();
    t_flag();
    t_disable();
    t_half();
    t_zero_ext();
    t_fsk();
    print_verdict();
  end
endmodule // ir_carrier_modulator_bench

`default_nettype wire

//--- ir_mod_pkg.sv
// Package with register map, field layout, reset values and timing for the IR modulator.
package ir_mod_pkg;

  // ****************************************************************
  // Register indices and byte addresses
  // ****************************************************************
  localparam logic [15:0] IDX_CONTROL_STATUS = 16'h0014;
  localparam logic [15:0] IDX_UPPER_NIBBLES  = 16'h0015;
  localparam logic [15:0] IDX_MARK_LOW       = 16'h0016;
  localparam logic [15:0] IDX_SPACE_LOW      = 16'h0017;
  localparam logic [15:0] IDX_ALT_CONTROL    = 16'h0018;
  localparam logic [15:0] IDX_OUT_LATCH      = 16'h0019;
  localparam logic [15:0] IDX_COUNT_LOW      = 16'h3FF2;
  localparam logic [15:0] IDX_COUNT_HIGH     = 16'h3FF3;

  // Byte address of a register is four times its index.
  function automatic logic [15:0] addr_of(input logic [15:0] idx);
    return {idx[13:0], 2'b00};
  endfunction

  // ****************************************************************
  // Control and status field positions
  // ****************************************************************
  localparam int BIT_ENABLE    = 0;
  localparam int BIT_IRQ_EN    = 1;
  localparam int BIT_MODE      = 2;
  localparam int BIT_BASE      = 3;
  localparam int BIT_EXT_SPACE = 4;
  localparam int BIT_CYCLE_END = 7;
  localparam int BIT_HALF_RATE = 0;
  localparam int BIT_LATCH     = 0;

  localparam logic [4:0]  CONTROL_RESET = 5'h00;
  localparam logic [11:0] BUFFER_RESET  = 12'h000;

  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam int          OSC_DIV     = 8;
  localparam logic [3:0]  PRE_LAST    = 4'(OSC_DIV - 1);
  localparam logic [3:0]  PRE_LAST_X2 = 4'(2 * OSC_DIV - 1);

  typedef enum {MOD_IDLE, MOD_MARK, MOD_SPACE} mod_state_t;

  typedef struct packed {
    logic ext_space;
    logic base;
    logic mode_fsk;
    logic irq_en;
    logic enable;
  } control_t;

endpackage
